// ===== src/sami_core.sv
// Purpose: serial control and result sequencer of an 8-bit successive-approximation converter
// Assumes: analog comparator and trial dac sit outside on the same clock
// Notes: the host serial clock is oversampled; one result per chip select low period
//
// Function
// - positive input below negative gives an all-zero result code
// - channel configuration is fixed during addressing, before conversion starts
// - single-ended mode: polarity bit picks channel 0 or 1, ground referenced
// - differential mode: polarity bit picks which channel is positive
// - single-input variant uses a fixed pair and takes no address bits
// - chip select low starts a transaction; device waits for a start bit
// - serial input is sampled on each rising serial clock during addressing
// - leading zeros are ignored; first one is the start bit
// - two-input variant takes single/differential bit then polarity bit
// - half a clock period of idle settling before conversion
// - serial input ignored from end of addressing until deselect
// - output leaves high impedance driving a leading zero for one period
// - decisions driven on falling clock edges, most significant first
// - conversion completes after eight clock periods of decisions
// - two-input variant repeats the result least significant first
// - after all bits the output is held low until deselect
// - single-input variant sends only the msb-first stream
// - input sampled only while output is high impedance, allowing shared wire
// - chip select high gives low power and high-impedance output
// - each multiplexer word applies to its own conversion only
// - result spans 256 equal-step codes

`timescale 1ns/100ps

module sami_core
(
    input wire logic clk,                  // system clock, 10 MHz
    input wire logic rstn,                 // synchronous reset, active low
    input wire logic sclk_pin,             // host serial clock pin
    input wire logic cs_n_pin,             // host chip select pin, active low
    input wire logic serial_in_pin,        // host serial data pin
    input wire logic two_input_variant,    // strap: 1 selects the two-input variant
    input wire logic comp_in,              // comparator: 1 when input is at or above trial code
    output logic data_out,                 // serial result data
    output logic data_out_oe_n,            // output enable, low while driving
    output logic [7:0] dac_code,           // trial code to the analog array
    output logic track_hold,               // 1 holds the sampled input
    output logic pos_chan,                 // channel assigned as positive input
    output logic neg_is_ground,            // negative input tied to ground
    output logic [7:0] result,             // last completed conversion
    output logic result_valid,             // one-cycle pulse when result updates
    output logic low_power                 // 1 while deselected
);

    // ------------------------------------------------------------
    // synchronised link
    // ------------------------------------------------------------
    sami_link_if link ();

    sami_sync u_sync
    (
        .clk(clk),
        .rstn(rstn),
        .sclk_pin(sclk_pin),
        .cs_n_pin(cs_n_pin),
        .serial_in_pin(serial_in_pin),
        .link(link.sync_side)
    );

    // one-hot weight of a trial bit
    function automatic logic [7:0] bit_weight(input logic [2:0] idx);
        bit_weight = 8'h01 << idx;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sami_pkg::sami_state_t state_reg;
    sami_pkg::sami_state_t state_next;
    logic addr_pos_reg;
    logic addr_pos_next;
    logic sgl_reg;
    logic sgl_next;
    logic two_ch_reg;
    logic two_ch_next;
    logic [2:0] idx_reg;
    logic [2:0] idx_next;
    logic [7:0] sar_reg;
    logic [7:0] sar_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] dac_reg;
    logic [7:0] dac_next;
    logic do_reg;
    logic do_next;
    logic oe_n_reg;
    logic oe_n_next;
    logic hold_reg;
    logic hold_next;
    logic pos_reg;
    logic pos_next;
    logic gnd_reg;
    logic gnd_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic valid_reg;
    logic valid_next;
    logic lp_reg;
    logic lp_next;
    logic [7:0] decided;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        addr_pos_next = addr_pos_reg;
        sgl_next = sgl_reg;
        two_ch_next = two_ch_reg;
        idx_next = idx_reg;
        sar_next = sar_reg;
        shift_next = shift_reg;
        dac_next = dac_reg;
        do_next = do_reg;
        oe_n_next = oe_n_reg;
        hold_next = hold_reg;
        pos_next = pos_reg;
        gnd_next = gnd_reg;
        result_next = result_reg;
        valid_next = 1'b0;
        lp_next = lp_reg;
        // comparator high keeps the trial bit; all-low decisions give zero
        // zero on reversal
        decided = comp_in ? (sar_reg | bit_weight(idx_reg)) : sar_reg;

        if (link.cs_n_s)
        begin
            state_next = sami_pkg::ST_IDLE;
            oe_n_next = 1'b1;
            do_next = 1'b0;
            hold_next = 1'b0;
            dac_next = sami_pkg::CODE_ZERO;
            lp_next = 1'b1;
        end
        else
        begin
            unique case (state_reg)
                sami_pkg::ST_IDLE:
                begin
                    // selected, await start
                    // strap taken per transaction so a variant change is clean
                    state_next = sami_pkg::ST_START;
                    lp_next = 1'b0;
                    two_ch_next = two_input_variant;
                end
                sami_pkg::ST_START:
                begin
                    if (link.sclk_rise && link.din_s)
                    begin
                        if (two_ch_reg)
                        begin
                            state_next = sami_pkg::ST_ADDR;
                            addr_pos_next = sami_pkg::ADDR_SGL;
                        end
                        else
                        begin
                            state_next = sami_pkg::ST_SETTLE;
                            pos_next = 1'b0;
                            gnd_next = 1'b0;
                        end
                    end
                end
                sami_pkg::ST_ADDR:
                begin
                    if (link.sclk_rise)
                    begin
                        if (addr_pos_reg == sami_pkg::ADDR_SGL)
                        begin
                            sgl_next = link.din_s;
                            addr_pos_next = sami_pkg::ADDR_ODD;
                        end
                        else
                        begin
                            pos_next = link.din_s;
                            gnd_next = sgl_reg;
                            state_next = sami_pkg::ST_SETTLE;
                        end
                    end
                end
                sami_pkg::ST_SETTLE:
                begin
                    if (link.sclk_fall)
                    begin
                        oe_n_next = 1'b0;
                        do_next = 1'b0;
                        hold_next = 1'b1;
                        idx_next = sami_pkg::MSB_IDX;
                        sar_next = sami_pkg::CODE_ZERO;
                        dac_next = bit_weight(sami_pkg::MSB_IDX);
                        state_next = sami_pkg::ST_MSB;
                    end
                end
                sami_pkg::ST_MSB:
                begin
                    if (link.sclk_fall)
                    begin
                        do_next = comp_in;
                        sar_next = decided;
                        if (idx_reg == sami_pkg::LSB_IDX)
                        begin
                            result_next = decided;
                            valid_next = 1'b1;
                            hold_next = 1'b0;
                            dac_next = sami_pkg::CODE_ZERO;
                            shift_next = decided >> 1;
                            idx_next = sami_pkg::LSB_IDX;
                            state_next = two_ch_reg ? sami_pkg::ST_LSB : sami_pkg::ST_TAIL;
                        end
                        else
                        begin
                            idx_next = idx_reg - 3'h1;
                            dac_next = decided | bit_weight(idx_reg - 3'h1);
                        end
                    end
                end
                sami_pkg::ST_LSB:
                begin
                    // bit 0 was the last msb-first bit, so the copy starts at bit 1
                    // lsb-first copy
                    if (link.sclk_fall)
                    begin
                        do_next = shift_reg[0];
                        shift_next = shift_reg >> 1;
                        idx_next = idx_reg + 3'h1;
                        if (idx_reg == sami_pkg::TAIL_LAST)
                        begin
                            state_next = sami_pkg::ST_TAIL;
                        end
                    end
                end
                sami_pkg::ST_TAIL:
                begin
                    if (link.sclk_fall)
                    begin
                        do_next = 1'b0;
                    end
                end
                default:
                begin
                    state_next = sami_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg <= sami_pkg::ST_IDLE;
            addr_pos_reg <= sami_pkg::ADDR_SGL;
            sgl_reg <= 1'b0;
            two_ch_reg <= 1'b0;
            idx_reg <= sami_pkg::MSB_IDX;
            sar_reg <= sami_pkg::CODE_ZERO;
            shift_reg <= sami_pkg::CODE_ZERO;
            dac_reg <= sami_pkg::CODE_ZERO;
            do_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            hold_reg <= 1'b0;
            pos_reg <= 1'b0;
            gnd_reg <= 1'b0;
            result_reg <= sami_pkg::CODE_ZERO;
            valid_reg <= 1'b0;
            lp_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            addr_pos_reg <= addr_pos_next;
            sgl_reg <= sgl_next;
            two_ch_reg <= two_ch_next;
            idx_reg <= idx_next;
            sar_reg <= sar_next;
            shift_reg <= shift_next;
            dac_reg <= dac_next;
            do_reg <= do_next;
            oe_n_reg <= oe_n_next;
            hold_reg <= hold_next;
            pos_reg <= pos_next;
            gnd_reg <= gnd_next;
            result_reg <= result_next;
            valid_reg <= valid_next;
            lp_reg <= lp_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    // driver off while input read
    assign data_out = do_reg;
    assign data_out_oe_n = oe_n_reg;
    assign dac_code = dac_reg;
    assign track_hold = hold_reg;
    assign pos_chan = pos_reg;
    assign neg_is_ground = gnd_reg;
    assign result = result_reg;
    assign result_valid = valid_reg;
    assign low_power = lp_reg;

endmodule

// ===== src/sami_pkg.sv
// Purpose: shared constants and types for the serial converter control interface
// Assumes: one 10 MHz system clock; host serial clock arrives on a pin
// Notes: the multi-bit indices, codes and reset values used by the design live here; single-bit flags other than addr_pos_reg reset to literals

package sami_pkg;

    // ------------------------------------------------------------
    // clock and result geometry
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;             // system clock period
    localparam int RES_W = 8;                       // result width
    localparam int RES_CODES = 256;                 // equal-step codes over the span
    localparam int SYNC_STAGES = 2;                 // pin synchroniser depth

    // ------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] MSB_IDX = 3'h7;          // first trial bit index
    localparam logic [2:0] LSB_IDX = 3'h0;          // last trial bit index
    localparam logic [2:0] TAIL_LAST = 3'h6;        // lsb-first copy sends 7 bits
    localparam logic [7:0] CODE_ZERO = 8'h00;       // all-zero code
    localparam logic ADDR_SGL = 1'h0;               // expect single/differential bit
    localparam logic ADDR_ODD = 1'h1;               // expect polarity bit
    localparam logic SYNC_CS_RST = 1'h1;            // chip select idles high
    localparam logic SYNC_LOW_RST = 1'h0;           // clock and data idle low

    // ------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,   // chip select high, low power
        ST_START = 7'h02,   // hunting for the start bit
        ST_ADDR  = 7'h04,   // taking the two multiplexer bits
        ST_SETTLE = 7'h08,  // half period, nothing happens
        ST_MSB   = 7'h10,   // decisions, msb first
        ST_LSB   = 7'h20,   // lsb-first copy
        ST_TAIL  = 7'h40    // output held low until deselect
    } sami_state_t;

endpackage

// ===== src/sami_link_if.sv
// Purpose: carrier between the pin synchroniser and the sequencer
// Assumes: all signals are on the system clock
// Notes: edge flags are one-cycle pulses

`timescale 1ns/100ps

interface sami_link_if;
    logic cs_n_s;       // synchronised chip select, active low
    logic din_s;        // synchronised serial input
    logic sclk_rise;    // serial clock rising edge pulse
    logic sclk_fall;    // serial clock falling edge pulse

    modport sync_side
    (
        output cs_n_s,
        output din_s,
        output sclk_rise,
        output sclk_fall
    );

    modport core_side
    (
        input cs_n_s,
        input din_s,
        input sclk_rise,
        input sclk_fall
    );
endinterface

// ===== src/sami_sync.sv
// Purpose: bring the host pins into the system clock and find serial clock edges
// Assumes: pins are asynchronous to clk; clk is well above twice the serial clock
// Notes: edge detection reads only the second stage and later

`timescale 1ns/100ps

module sami_sync
(
    input wire logic clk,                  // system clock
    input wire logic rstn,                 // synchronous reset, active low
    input wire logic sclk_pin,             // host serial clock
    input wire logic cs_n_pin,             // host chip select, active low
    input wire logic serial_in_pin,        // host serial data
    sami_link_if.sync_side link            // synchronised view
);

    logic [1:0] cs_reg;
    logic [1:0] cs_next;
    logic [1:0] din_reg;
    logic [1:0] din_next;
    logic [2:0] sclk_reg;
    logic [2:0] sclk_next;

    // ------------------------------------------------------------
    // two-stage synchronisers, third sclk stage for edges
    // ------------------------------------------------------------
    always_comb
    begin
        cs_next = {cs_reg[0], cs_n_pin};
        din_next = {din_reg[0], serial_in_pin};
        sclk_next = {sclk_reg[1:0], sclk_pin};
    end

    // register the stages; chip select resets to deselected
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cs_reg <= {sami_pkg::SYNC_CS_RST, sami_pkg::SYNC_CS_RST};
            din_reg <= {sami_pkg::SYNC_LOW_RST, sami_pkg::SYNC_LOW_RST};
            sclk_reg <= {3{sami_pkg::SYNC_LOW_RST}};
        end
        else
        begin
            cs_reg <= cs_next;
            din_reg <= din_next;
            sclk_reg <= sclk_next;
        end
    end

    // edge pulses compare stage two with stage three only
    assign link.cs_n_s = cs_reg[1];
    assign link.din_s = din_reg[1];
    assign link.sclk_rise = sclk_reg[1] & ~sclk_reg[2];
    assign link.sclk_fall = ~sclk_reg[1] & sclk_reg[2];

endmodule

// ===== bench/sami_core_assertions.sv
// Purpose: port checks on the converter sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: pin latencies allow for the two-flop synchroniser

`timescale 1ns/100ps

module sami_checker
(
    input wire logic clk,               // clock
    input wire logic rstn,              // reset
    input wire logic sclk_pin,          // serial clock
    input wire logic cs_n_pin,          // select
    input wire logic serial_in_pin,     // serial in
    input wire logic two_input_variant, // strap
    input wire logic comp_in,           // comparator
    input wire logic data_out,          // serial out
    input wire logic data_out_oe_n,     // enable
    input wire logic [7:0] dac_code,    // trial code
    input wire logic track_hold,        // hold
    input wire logic pos_chan,          // positive channel
    input wire logic neg_is_ground,     // single-ended
    input wire logic [7:0] result,      // result
    input wire logic result_valid,      // result pulse
    input wire logic low_power          // deselected
);
    // ----------------------------------------
    // conversion sequence properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // output leaving high impedance marks the start of a conversion
    sequence conv_begin;
        $fell(data_out_oe_n);
    endsequence

    // eight decisions at twelve clocks each, unless the host aborts
    sequence conv_end;
        ##[1:200] (result_valid || cs_n_pin);
    endsequence

    desel_hiz_a: assert property (cs_n_pin [*6] |-> data_out_oe_n && low_power)
        else $error("device still active after deselect");
    power_hiz_a: assert property (low_power |-> data_out_oe_n)
        else $error("output driven in low power");
    lead_zero_a: assert property (conv_begin |-> !data_out && track_hold && dac_code == 8'h80)
        else $error("conversion start not a leading zero");
    conv_bound_a: assert property (conv_begin |-> conv_end)
        else $error("conversion did not complete");
    last_bit_a: assert property (result_valid |-> data_out == result[0] && !track_hold
        && dac_code == 8'h00)
        else $error("last decision and result disagree");
    valid_pulse_a: assert property (result_valid |=> !result_valid)
        else $error("result pulse too long");
    result_hold_a: assert property ($changed(result) |-> result_valid)
        else $error("result changed without pulse");
    config_fixed_a: assert property ($changed(pos_chan) || $changed(neg_is_ground)
        |-> data_out_oe_n && !track_hold)
        else $error("channel changed during conversion");
    hiz_quiet_a: assert property (data_out_oe_n |-> !data_out && !track_hold)
        else $error("converting while output released");
    data_fall_a: assert property (!data_out_oe_n && $changed(data_out) |-> !sclk_pin)
        else $error("output changed with clock high");
endmodule

bind sami_core sami_checker i_chk
(
    .clk(clk), .rstn(rstn), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .serial_in_pin(serial_in_pin), .two_input_variant(two_input_variant),
    .comp_in(comp_in), .data_out(data_out), .data_out_oe_n(data_out_oe_n),
    .dac_code(dac_code), .track_hold(track_hold), .pos_chan(pos_chan),
    .neg_is_ground(neg_is_ground), .result(result), .result_valid(result_valid),
    .low_power(low_power)
);

// ===== bench/sami_host_model.sv
// Purpose: host controller driving the converter pins
// Assumes: clk is the 10 MHz system clock
// Notes: samples the output just before each serial clock rise

`timescale 1ns/100ps

module sami_host_model
(
    input wire logic clk,           // clock
    input wire logic data_out,      // device data
    input wire logic data_out_oe_n, // device enable
    output logic sclk_pin,          // serial clock
    output logic cs_n_pin,          // select, active low
    output logic serial_in_pin      // data to device
);
    // ----------------------------------------
    // frame generator
    // ----------------------------------------
    // phase well below limit
    localparam int HALF = 6;

    // clock stands low and select high between frames
    initial
    begin
        sclk_pin = 1'b0;
        cs_n_pin = 1'b1;
        serial_in_pin = 1'b0;
    end

    // one select period: zeros, start bit, address bits, then sampled bits
    task automatic frame(input int nz, input int na, input logic [1:0] addr,
        input int ns, output logic [31:0] cap, output logic [31:0] oe);
        int r;
        int first;
        first = nz + na + 1;
        cap = '0;
        oe = '1;
        cs_n_pin <= 1'b0;
        for (r = 0; r < first + ns; r++)
        begin
            if (r < first)
                serial_in_pin <= (r == nz) ? 1'b1 : (r < nz) ? 1'b0 : addr[nz + 2 - r];
            else
                serial_in_pin <= ~serial_in_pin;
            repeat (HALF) @(posedge clk);
            if (r >= first)
            begin
                // a released line reads back inverted, so a missing driver cannot pass
                cap[r - first] = data_out_oe_n ? ~data_out : data_out;
                oe[r - first] = data_out_oe_n;
            end
            sclk_pin <= 1'b1;
            repeat (HALF) @(posedge clk);
            sclk_pin <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        cs_n_pin <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ===== bench/test_serial_adc_mux_interface.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: host model drives pins, bench plays the comparator
// Notes: junk on the data line after addressing must be ignored

`timescale 1ns/100ps

module test_serial_adc_mux_interface;
    logic clk, rstn, two_input_variant, comp_in, sclk_pin, cs_n_pin, serial_in_pin;
    logic data_out, data_out_oe_n, track_hold, pos_chan, neg_is_ground, result_valid;
    logic low_power;
    logic [7:0] dac_code;
    logic [7:0] result;
    int num_errors = 0;
    int num_checks = 0;
    int n_valid = 0;
    int v0 = 0;
    int v1 = 0;

    // ----------------------------------------
    // clock, design, host and analog side
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    sami_core i_dut
    (
        .clk(clk), .rstn(rstn), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
        .serial_in_pin(serial_in_pin), .two_input_variant(two_input_variant),
        .comp_in(comp_in), .data_out(data_out), .data_out_oe_n(data_out_oe_n),
        .dac_code(dac_code), .track_hold(track_hold), .pos_chan(pos_chan),
        .neg_is_ground(neg_is_ground), .result(result), .result_valid(result_valid),
        .low_power(low_power)
    );

    sami_host_model i_host
    (
        .clk(clk), .data_out(data_out), .data_out_oe_n(data_out_oe_n),
        .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .serial_in_pin(serial_in_pin)
    );

    // comparator: a negative difference never wins, so the search ends at zero
    always @(posedge clk)
    begin
        comp_in <= ((pos_chan ? v1 : v0) - (neg_is_ground ? 0 : (pos_chan ? v0 : v1)))
            >= int'(dac_code);
        if (result_valid === 1'b1)
            n_valid <= n_valid + 1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // frames 0-9 two-input, 10-13 single-input; frame 12 aborted early
    initial
    begin
        int i, k, nz, ns, vp, vn, diff, prev, base;
        logic two;
        logic [1:0] a;
        logic [31:0] cap, oe, mask, s;
        rstn = 1'b0;
        two_input_variant = 1'b0;
        prev = 0;
        void'($urandom(32'hF4B6));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check("reset enable", data_out_oe_n, 32'h1);
        check("reset result", result, 32'h0);
        for (i = 0; i < 14; i++)
        begin
            two = (i < 10);
            a = i[1:0];
            nz = $urandom_range(3, 0);
            v0 = (i == 8) ? 255 : (i == 9) ? 200 : $urandom_range(255, 0);
            v1 = (i == 8) ? 0 : (i == 9) ? 3 : $urandom_range(255, 0);
            ns = (i == 12) ? 4 : two ? 18 : 12;
            vp = (two && a[0]) ? v1 : v0;
            vn = (two && a[1]) ? 0 : ((two && a[0]) ? v0 : v1);
            diff = (vp > vn) ? vp - vn : 0;
            s = '0;
            for (k = 0; k < 8; k++)
            begin
                s[1 + k] = diff[7 - k];
                s[8 + k] = two && k > 0 && diff[k];
            end
            mask = (32'h1 << ns) - 32'h1;
            two_input_variant <= two;
            @(posedge clk);
            // pulse counter has one writer; take a snapshot instead of clearing it
            base = n_valid;
            i_host.frame(nz, two ? 2 : 0, a, ns, cap, oe);
            check("msb stream", cap & mask & 32'h1FF, s & mask & 32'h1FF);
            check("tail stream", cap & mask & ~32'h1FF, s & mask & ~32'h1FF);
            check("drive window", oe, ~mask);
            check("result", result, (ns == 4) ? prev : diff);
            check("valid count", n_valid - base, (ns == 4) ? 0 : 1);
            check("positive channel", pos_chan, two & a[0]);
            check("ground reference", neg_is_ground, two & a[1]);
            check("idle enable", data_out_oe_n, 32'h1);
            check("low power", low_power, 32'h1);
            prev = (ns == 4) ? prev : diff;
        end
        results();
    end
endmodule
